/* core/rsq_pkg.sv */
// reset sequencer package: register map, field layout, reset presets, states
// assumes a 200 MHz system clock and a 32-bit AXI4-Lite register port
package rsq_pkg;

  // minimum low time of the reset pin, in system clocks
  localparam int          RST_MIN_CLKS   = 10;

  // reset vector locations
  localparam logic [23:0] VEC_ADDR_LO    = 24'hFFFF00;
  localparam logic [23:0] VEC_ADDR_MID   = 24'hFFFF01;
  localparam logic [23:0] VEC_ADDR_HI    = 24'hFFFF02;

  // core register presets
  localparam logic [31:0] XSP_RESET      = 32'h0000_0100;
  localparam logic [2:0]  IML_RESET      = 3'h7;
  localparam logic        MAX_RESET      = 1'b1;
  localparam logic [2:0]  RFP_RESET      = 3'h0;

  // status register field positions
  localparam int          SR_IML_LSB     = 12;
  localparam int          SR_MAX_BIT     = 11;
  localparam int          SR_RFP_LSB     = 8;

  // clock gear: code n divides by 2**(n+1), code 4 is the slowest
  localparam logic [2:0]  GEAR_RESET     = 3'h4;
  localparam logic [2:0]  GEAR_MAX       = 3'h4;

  // register byte offsets
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_PC        = 8'h04;
  localparam logic [7:0]  ADDR_SR        = 8'h08;
  localparam logic [7:0]  ADDR_XSP       = 8'h0C;
  localparam logic [7:0]  ADDR_BUSCFG    = 8'h10;
  localparam logic [7:0]  ADDR_PORTMODE  = 8'h14;
  localparam logic [7:0]  ADDR_STAT      = 8'h18;

  // control register fields and default
  localparam int          CTRL_GEAR_LSB  = 0;
  localparam int          CTRL_CLKEN_BIT = 4;
  localparam int          CTRL_ALEEN_BIT = 5;
  localparam logic        CLKEN_RESET    = 1'b1;
  localparam logic        ALEEN_RESET    = 1'b1;

  // peripheral defaults: external bus config and port mode (zero is port mode)
  localparam logic [7:0]  BUSCFG_RESET   = 8'h00;
  localparam logic [7:0]  PORTMODE_RESET = 8'h00;
  localparam logic        ROM_BUS_16     = 1'b1;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [2:0] {ST_HOLD, ST_VEC, ST_RUN} rsq_state_e;

endpackage

/* core/rsq_pin_sync.sv */
// pin synchroniser with a consecutive-low filter
// assumes the pin is asynchronous to clk; output is a level on clk
`timescale 1ns/1ps
`default_nettype none
module rsq_pin_sync #(
  parameter int MIN_LOW = 1
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin,
  output logic      pin_sync,
  output logic      low_seen
);

  logic       meta_q;
  logic       sync_q;
  logic [7:0] cnt_q;

  // two flops before anything looks at the pin
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  // count consecutive low samples, saturating; a high sample restarts it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
    end else if (sync_q) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'(MIN_LOW)) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign pin_sync = sync_q;
  assign low_seen = (cnt_q == 8'(MIN_LOW));

endmodule
`default_nettype wire

/* core/rsq_top.sv */
// reset acceptance and initialisation sequencer with an AXI4-Lite register port
// assumes mem_* is a same-clock byte read port of the bus controller and that
// the core waits for cpu_run before fetching
`timescale 1ns/1ps
`default_nettype none
module rsq_top
  import rsq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins
  input  wire logic        reset_pin_n,
  input  wire logic        bus_width_select_pin,
  output logic             clk_out,
  input  wire logic        ale_req,
  output logic             ale_out,
  output logic             ale_oe_n,
  // vector read port
  output logic             mem_req,
  output logic [23:0]      mem_addr,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_ack,
  // core and peripheral side
  output logic             in_reset,
  output logic             periph_rst,
  output logic             cpu_run,
  output logic             fetch_go,
  output logic [23:0]      fetch_addr,
  output logic [15:0]      sr_out,
  output logic [31:0]      xsp_out,
  output logic [2:0]       gear_out,
  output logic             rom_bus_16,
  output logic [7:0]       ext_bus_cfg,
  output logic [7:0]       port_mode
);

  rsq_state_e  state_q;
  logic [1:0]  vec_idx_q;
  logic [23:0] pc_q;
  logic [2:0]  iml_q;
  logic        max_q;
  logic [2:0]  rfp_q;
  logic [31:0] xsp_q;
  logic        fetch_go_q;
  logic        mem_req_q;
  logic [23:0] mem_addr_q;
  logic [2:0]  gear_q;
  logic        clken_q;
  logic        aleen_q;
  logic [7:0]  buscfg_q;
  logic [7:0]  portmode_q;
  logic [4:0]  div_cnt_q;
  logic        clk_out_q;
  logic        accepted_q;
  logic        periph_rst_q;
  logic        rst_pin_s;
  logic        rst_low_seen;
  logic        bw_pin_s;
  logic        accept_pulse;
  logic        aw_hold_q;
  logic [7:0]  awaddr_q;
  logic        w_hold_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic        wr_go;
  logic [4:0]  half_period;
  logic [2:0]  gear_wr;

  // reset pin filter: two sync flops then a run of low samples
  rsq_pin_sync #(
    .MIN_LOW (RST_MIN_CLKS)
  ) u_rst_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin      (reset_pin_n),
    .pin_sync (rst_pin_s),
    .low_seen (rst_low_seen)
  );

  // bus width pin is only observed for status, never for bus sizing
  rsq_pin_sync #(
    .MIN_LOW (1)
  ) u_bw_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin      (bus_width_select_pin),
    .pin_sync (bw_pin_s),
    .low_seen ()
  );

  // shorter low pulses never reach the filter count and are dropped
  assign accept_pulse = rst_low_seen && !accepted_q;

  // accepted stays set until the pin is seen high again
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      accepted_q <= 1'b0;
    end else if (rst_pin_s) begin
      accepted_q <= 1'b0;
    end else if (rst_low_seen) begin
      accepted_q <= 1'b1;
    end
  end

  // sequencer: hold while in reset, read the vector, then run
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q   <= ST_HOLD;
      vec_idx_q <= 2'h0;
    end else if (accept_pulse) begin
      state_q   <= ST_HOLD;
      vec_idx_q <= 2'h0;
    end else begin
      case (state_q)
        ST_HOLD: begin
          if (rst_pin_s) begin
            state_q   <= ST_VEC;
            vec_idx_q <= 2'h0;
          end
        end
        ST_VEC: begin
          if (mem_req_q && mem_ack) begin
            if (vec_idx_q == 2'h2) begin
              state_q <= ST_RUN;
            end
            vec_idx_q <= vec_idx_q + 2'h1;
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_HOLD;
        end
      endcase
    end
  end

  // vector byte requests, one outstanding, address by byte index
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_req_q  <= 1'b0;
      mem_addr_q <= 24'h000000;
    end else if (accept_pulse) begin
      mem_req_q  <= 1'b0;
    end else if (mem_req_q && mem_ack) begin
      mem_req_q  <= 1'b0;
    end else if (state_q == ST_VEC) begin
      mem_req_q  <= 1'b1;
      case (vec_idx_q)
        2'h0:    mem_addr_q <= VEC_ADDR_LO;
        2'h1:    mem_addr_q <= VEC_ADDR_MID;
        default: mem_addr_q <= VEC_ADDR_HI;
      endcase
    end
  end

  // program counter assembled low byte first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= 24'h000000;
    end else if (state_q == ST_VEC && mem_req_q && mem_ack) begin
      case (vec_idx_q)
        2'h0:    pc_q[7:0]   <= mem_rdata;
        2'h1:    pc_q[15:8]  <= mem_rdata;
        default: pc_q[23:16] <= mem_rdata;
      endcase
    end
  end

  // one-cycle start pulse as the last vector byte lands
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_go_q <= 1'b0;
    end else begin
      fetch_go_q <= (state_q == ST_VEC) && mem_req_q && mem_ack && (vec_idx_q == 2'h2);
    end
  end

  // status register fields and system stack pointer presets; nothing else
  // in the core is touched, so general registers and RAM survive reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      iml_q <= IML_RESET;
      max_q <= MAX_RESET;
      rfp_q <= RFP_RESET;
      xsp_q <= XSP_RESET;
    end else if (accept_pulse) begin
      iml_q <= IML_RESET;
      max_q <= MAX_RESET;
      rfp_q <= RFP_RESET;
      xsp_q <= XSP_RESET;
    end
  end

  // peripheral reset strobe follows each acceptance
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      periph_rst_q <= 1'b1;
    end else begin
      periph_rst_q <= accept_pulse;
    end
  end

  // write channel: address and data are caught independently
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign wr_go         = aw_hold_q && w_hold_q;
  // clamp taken from the held word, since the bus data may already have moved on
  assign gear_wr       = (wdata_q[CTRL_GEAR_LSB +: 3] > GEAR_MAX) ? GEAR_MAX : wdata_q[CTRL_GEAR_LSB +: 3];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= 8'h00;
      w_hold_q  <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // write response: unmapped offsets answer SLVERR, read-only ones are ignored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      case (awaddr_q)
        ADDR_CTRL, ADDR_PC, ADDR_SR, ADDR_XSP,
        ADDR_BUSCFG, ADDR_PORTMODE, ADDR_STAT: bresp_q <= RESP_OKAY;
        default:                               bresp_q <= RESP_SLVERR;
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // software registers; acceptance wins over a write in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gear_q     <= GEAR_RESET;
      clken_q    <= CLKEN_RESET;
      aleen_q    <= ALEEN_RESET;
      buscfg_q   <= BUSCFG_RESET;
      portmode_q <= PORTMODE_RESET;
    end else if (accept_pulse) begin
      gear_q     <= GEAR_RESET;
      clken_q    <= CLKEN_RESET;
      aleen_q    <= ALEEN_RESET;
      buscfg_q   <= BUSCFG_RESET;
      portmode_q <= PORTMODE_RESET;
    end else if (wr_go && wstrb_q[0]) begin
      case (awaddr_q)
        ADDR_CTRL: begin
          gear_q  <= gear_wr;
          clken_q <= wdata_q[CTRL_CLKEN_BIT];
          aleen_q <= wdata_q[CTRL_ALEEN_BIT];
        end
        ADDR_BUSCFG:   buscfg_q   <= wdata_q[7:0];
        ADDR_PORTMODE: portmode_q <= wdata_q[7:0];
        default: begin
          buscfg_q <= buscfg_q;
        end
      endcase
    end
  end

  // read channel: one read in flight, data registered
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL:     rdata_q <= {26'h0, aleen_q, clken_q, 1'b0, gear_q};
        ADDR_PC:       rdata_q <= {8'h00, pc_q};
        ADDR_SR:       rdata_q <= {16'h0000, sr_out};
        ADDR_XSP:      rdata_q <= xsp_q;
        ADDR_BUSCFG:   rdata_q <= {24'h0, buscfg_q};
        ADDR_PORTMODE: rdata_q <= {24'h0, portmode_q};
        ADDR_STAT:     rdata_q <= {26'h0, bw_pin_s, accepted_q, cpu_run, in_reset, rst_pin_s, ROM_BUS_16};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // clock output divider, half period of 2**gear system clocks
  assign half_period = 5'h01 << gear_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_q <= 5'h00;
      clk_out_q <= 1'b1;
    end else if (accept_pulse || state_q == ST_HOLD || !clken_q) begin
      // acceptance parks the pin in the same cycle the hold state begins
      div_cnt_q <= 5'h00;
      clk_out_q <= 1'b1;
    end else if (div_cnt_q + 5'h01 >= half_period) begin
      div_cnt_q <= 5'h00;
      clk_out_q <= !clk_out_q;
    end else begin
      div_cnt_q <= div_cnt_q + 5'h01;
    end
  end

  // status register layout packed from its fields
  always_comb begin
    sr_out                     = 16'h0000;
    sr_out[SR_IML_LSB +: 3]    = iml_q;
    sr_out[SR_MAX_BIT]         = max_q;
    sr_out[SR_RFP_LSB +: 3]    = rfp_q;
  end

  assign in_reset      = (state_q == ST_HOLD);
  assign periph_rst    = periph_rst_q;
  // the core is stalled, not cleared, so its other state persists
  assign cpu_run       = (state_q == ST_RUN);
  assign fetch_go      = fetch_go_q;
  assign fetch_addr    = pc_q;
  assign xsp_out       = xsp_q;
  assign gear_out      = gear_q;
  assign mem_req       = mem_req_q;
  assign mem_addr      = mem_addr_q;
  assign clk_out       = clk_out_q;
  // ALE released to high impedance while held in reset or when disabled
  assign ale_oe_n      = in_reset || !aleen_q;
  assign ale_out       = ale_req && !ale_oe_n;
  assign rom_bus_16    = ROM_BUS_16;
  // external width comes only from the register, the pin is ignored
  assign ext_bus_cfg   = buscfg_q;
  assign port_mode     = portmode_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

endmodule
`default_nettype wire

/* bench/rsq_top_asserts.sv */
// checker for the reset sequencer: pin filter, hold-state pins, presets, vector fetch
// assumes it is bound into rsq_top and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module rsq_top_asserts
  import rsq_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        reset_pin_n,
  input wire logic        clk_out,
  input wire logic        ale_out,
  input wire logic        ale_oe_n,
  input wire logic        mem_req,
  input wire logic [23:0] mem_addr,
  input wire logic [7:0]  mem_rdata,
  input wire logic        mem_ack,
  input wire logic        in_reset,
  input wire logic        cpu_run,
  input wire logic        fetch_go,
  input wire logic [23:0] fetch_addr,
  input wire logic [15:0] sr_out,
  input wire logic [31:0] xsp_out,
  input wire logic [2:0]  gear_out,
  input wire logic        rom_bus_16,
  input wire logic [7:0]  ext_bus_cfg,
  input wire logic [7:0]  port_mode,
  input wire logic        periph_rst
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  localparam logic [15:0] SR_PRE = {1'h0, IML_RESET, MAX_RESET, RFP_RESET, 8'h00};
  logic [3:0] low_cnt_q;
  logic [7:0] byte_lo_q;
  logic [7:0] byte_mid_q;

  // raw pin low run, saturating so a long hold stays visible
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) low_cnt_q <= 4'h0;
    else if (reset_pin_n) low_cnt_q <= 4'h0;
    else if (low_cnt_q != 4'hF) low_cnt_q <= low_cnt_q + 4'h1;
  end
  // vector bytes as the memory hands them over
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_lo_q <= 8'h00;
      byte_mid_q <= 8'h00;
    end else if (mem_req && mem_ack) begin
      if (mem_addr == VEC_ADDR_LO) byte_lo_q <= mem_rdata;
      if (mem_addr == VEC_ADDR_MID) byte_mid_q <= mem_rdata;
    end
  end

  sequence lo_taken;
    mem_req && mem_ack && mem_addr == VEC_ADDR_LO && reset_pin_n;
  endsequence
  sequence last_taken;
    mem_req && mem_ack && mem_addr == VEC_ADDR_HI && reset_pin_n;
  endsequence
  sequence run_then_fetch;
    cpu_run ##[0:1] fetch_go;
  endsequence

  chk_clk_held: assert property (in_reset |-> clk_out)
    else $error("clock output not high in reset");
  chk_ale_float: assert property (in_reset |-> ale_oe_n && !ale_out)
    else $error("address latch pin driven in reset");
  chk_rom_width: assert property (rom_bus_16)
    else $error("rom bus not sixteen bits");
  chk_core_presets: assert property ($rose(in_reset) |=> sr_out == SR_PRE && xsp_out == XSP_RESET)
    else $error("status or stack preset wrong");
  chk_periph_defaults: assert property ($rose(in_reset) |=>
    gear_out == GEAR_RESET && ext_bus_cfg == BUSCFG_RESET && port_mode == PORTMODE_RESET)
    else $error("peripheral defaults not restored");
  chk_periph_pulse: assert property ($rose(in_reset) |-> periph_rst ##1 !periph_rst)
    else $error("peripheral reset strobe wrong");
  chk_accept_min: assert property ($rose(in_reset) |-> low_cnt_q >= 4'hA)
    else $error("reset accepted too early");
  chk_accept_max: assert property (low_cnt_q == 4'hF |-> in_reset)
    else $error("long reset not accepted");
  chk_vec_next: assert property (lo_taken |=> !mem_req ##[1:2] (mem_req && mem_addr == VEC_ADDR_MID))
    else $error("vector byte order wrong");
  chk_vec_run: assert property (last_taken |=> run_then_fetch)
    else $error("no start after vector");
  chk_fetch_addr: assert property (last_taken |=> fetch_addr == {$past(mem_rdata), byte_mid_q, byte_lo_q})
    else $error("fetch address not from vector");
endmodule

bind rsq_top rsq_top_asserts u_asserts (.clk, .sys_rst, .reset_pin_n, .clk_out, .ale_out, .ale_oe_n,
  .mem_req, .mem_addr, .mem_rdata, .mem_ack, .in_reset, .cpu_run, .fetch_go, .fetch_addr,
  .sr_out, .xsp_out, .gear_out, .rom_bus_16, .ext_bus_cfg, .port_mode, .periph_rst);
`default_nettype wire

/* bench/rsq_vec_mem.sv */
// vector memory on the far side of the byte read port
// assumes same-clock req/ack; the bench sets the vector and the answer delay
`timescale 1ns/1ps
`default_nettype none
module rsq_vec_mem (
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic [23:0] mem_addr,
  input  wire logic [23:0] vec,
  input  wire logic [7:0]  delay,
  output logic [7:0]       mem_rdata,
  output logic             mem_ack
);
  logic [7:0] wait_q;
  // one-cycle ack after the wait; data churns whenever it is not valid
  initial begin
    mem_ack = 1'h0;
    mem_rdata = 8'hA5;
    wait_q = 8'h00;
    forever @(posedge clk) begin
      if (mem_ack || !mem_req) begin
        mem_ack <= 1'h0;
        wait_q <= 8'h00;
        mem_rdata <= ~mem_rdata;
      end else if (wait_q >= delay) begin
        mem_ack <= 1'h1;
        mem_rdata <= vec[mem_addr[1:0]*8 +: 8];
      end else begin
        wait_q <= wait_q + 8'h01;
        mem_rdata <= ~mem_rdata;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/rsq_top_tb.sv */
// self-checking bench for the reset sequencer: registers, pin filter, vector fetch
// assumes rsq_top, its checker and the vector memory model are compiled first
`timescale 1ns/1ps
`default_nettype none
module rsq_top_tb;
  import rsq_pkg::*;
  logic        clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, reset_pin_n, bus_width_select_pin, clk_out, ale_req;
  logic        ale_oe_n, mem_req, mem_ack, in_reset, cpu_run;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, mem_rdata, delay;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd, d, e;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [23:0] mem_addr, fetch_addr, vec;
  int          error_cnt, checks_done, g;

  rsq_top dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .reset_pin_n, .bus_width_select_pin, .clk_out, .ale_req, .ale_out(),
    .ale_oe_n, .mem_req, .mem_addr, .mem_rdata, .mem_ack, .in_reset, .periph_rst(), .cpu_run,
    .fetch_go(), .fetch_addr, .sr_out(), .xsp_out(), .gear_out(), .rom_bus_16(),
    .ext_bus_cfg(), .port_mode());
  rsq_vec_mem u_mem (.clk, .mem_req, .mem_addr, .vec, .delay, .mem_rdata, .mem_ack);

  // 200 MHz clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // latch strobe requests keep moving so the output gate is exercised
  initial begin
    ale_req = 1'h0;
    forever @(posedge clk) ale_req <= ~ale_req;
  end

  task automatic stop_test;
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // cut a hang short well beyond the expected run length
  initial begin
    #100000;
    error_cnt++;
    stop_test;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_ctrl(input logic [31:0] w);
    return {26'h0, w[5:4], 1'h0, (w[2:0] > GEAR_MAX) ? GEAR_MAX : w[2:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // handshakes are judged just before the edge that completes them
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] w, output logic [1:0] rs);
    logic aw_t, w_t, b_t;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    b_t = 1'h0;
    while (!b_t) begin
      @(negedge clk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clk);
      if (aw_t) s_axi_awvalid <= 1'h0;
      if (w_t) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
    logic ar_t, r_t;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    r_t = 1'h0;
    while (!r_t) begin
      @(negedge clk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk);
      if (ar_t) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] x, input logic [1:0] xr);
    logic [31:0] rd;
    logic [1:0]  rs;
    axi_rd(a, rd, rs);
    chk(rd, x);
    chk({30'h0, rs}, {30'h0, xr});
  endtask
  // wait for the core to start, then compare the start address both ways
  task automatic wait_run(input logic [23:0] v);
    int n;
    n = 0;
    while (!cpu_run && n < 2000) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
    chk({7'h0, cpu_run, fetch_addr}, {8'h01, v});
    reg_chk(ADDR_PC, {8'h00, v}, RESP_OKAY);
  endtask
  // hold the pin low for n clocks, checking the pins while held
  task automatic pin_pulse(input int n, input logic acc);
    logic seen;
    seen = 1'h0;
    @(posedge clk);
    reset_pin_n <= 1'h0;
    repeat (n) begin
      @(negedge clk);
      seen |= in_reset;
      if (in_reset) chk({30'h0, clk_out, ale_oe_n}, 32'h3);
    end
    @(posedge clk);
    reset_pin_n <= 1'h1;
    chk({31'h0, seen}, {31'h0, acc});
  endtask
  task automatic count_toggles(input int x);
    int t;
    logic p;
    t = 0;
    @(negedge clk);
    p = clk_out;
    repeat (64) begin
      @(negedge clk);
      if (clk_out !== p) t++;
      p = clk_out;
    end
    chk(t, x);
  endtask

  // main sequence
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_wstrb = 4'hF;
    sys_rst = 1'h1;
    reset_pin_n = 1'h1;
    bus_width_select_pin = 1'h1;
    rnd = lfsr(32'h0001_3679);
    vec = rnd[23:0];
    delay = 8'h00;
    error_cnt = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    reg_chk(ADDR_CTRL, 32'h34, RESP_OKAY);
    reg_chk(ADDR_SR, 32'h7800, RESP_OKAY);
    reg_chk(ADDR_XSP, 32'h100, RESP_OKAY);
    axi_rd(ADDR_STAT, d, r);
    chk({31'h0, d[0]}, 32'h1);
    wait_run(vec);
    // every gear code; codes above the slowest clamp to it
    for (g = 0; g < 8; g++) begin
      d = {26'h0, 3'h6, g[2:0]};
      e = exp_ctrl(d);
      axi_wr(ADDR_CTRL, d, r);
      reg_chk(ADDR_CTRL, e, RESP_OKAY);
      repeat (40) @(posedge clk);
      count_toggles(64 >> e[2:0]);
    end
    // random bus setup with the width pin low: only the register counts
    @(posedge clk);
    bus_width_select_pin <= 1'h0;
    repeat (4) begin
      rnd = lfsr(rnd);
      axi_wr(ADDR_BUSCFG, rnd, r);
      reg_chk(ADDR_BUSCFG, {24'h0, rnd[7:0]}, RESP_OKAY);
      axi_wr(ADDR_PORTMODE, rnd >> 8, r);
      reg_chk(ADDR_PORTMODE, {24'h0, rnd[15:8]}, RESP_OKAY);
    end
    axi_rd(ADDR_STAT, d, r);
    chk({31'h0, d[5]}, 32'h0);
    axi_wr(ADDR_XSP, rnd, r);
    reg_chk(ADDR_XSP, 32'h100, RESP_OKAY);
    axi_wr(8'h1C, rnd, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    reg_chk(8'h1C, 32'h0, RESP_SLVERR);
    // a glitch is ignored; a long hold restores defaults and refetches slowly
    axi_wr(ADDR_CTRL, 32'h31, r);
    pin_pulse(8, 1'h0);
    reg_chk(ADDR_CTRL, 32'h31, RESP_OKAY);
    rnd = lfsr(rnd);
    vec = rnd[23:0];
    delay = 8'h14;
    pin_pulse(16, 1'h1);
    reg_chk(ADDR_CTRL, 32'h34, RESP_OKAY);
    reg_chk(ADDR_BUSCFG, 32'h0, RESP_OKAY);
    reg_chk(ADDR_PORTMODE, 32'h0, RESP_OKAY);
    reg_chk(ADDR_SR, 32'h7800, RESP_OKAY);
    // second acceptance lands in the middle of the slow fetch
    rnd = lfsr(rnd);
    vec = rnd[23:0];
    pin_pulse(16, 1'h1);
    wait_run(vec);
    stop_test;
  end
endmodule
`default_nettype wire
